// [hw/icu_capture_unit.sv]
// Purpose: input capture unit with edge prescaler and Wishbone registers
// Assumes: timebase count arrives on clk_i; capture pin is asynchronous
// Notes: compare and pwm modes are not part of this unit
//
// Notes on behaviour
// RULE_01: qualifying event copies 16-bit timebase into capture
// RULE_02: mode picks falling, rising, 4th or 16th rise
// RULE_03: capture sets flag; only software clears it
// RULE_04: later capture overwrites unread value, no overrun
// RULE_05: edges seen whatever the pin direction
// RULE_06: software keeps the pin an input
// RULE_07: timebase runs timer or synchronized counter mode
// RULE_08: timebase clocked by instruction clock or external
// RULE_09: mode change may raise a spurious flag
// RULE_10: prescaler held clear when off or not capturing; code clears it only outside the capture modes, the enable bit is ignored
// RULE_11: every reset clears the prescaler
// RULE_12: prescaler change keeps count, may capture falsely
// RULE_13: capture keeps running while timebase runs, sleep too
// RULE_14: pin synchronised, edges give one-cycle capture strobe

module icu_capture_unit
    import icu_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [icu_pkg::ICU_ADDR_W-1:0] wb_adr_i,
    input wire logic [icu_pkg::ICU_SEL_W-1:0] wb_sel_i,
    input wire logic [icu_pkg::ICU_DATA_W-1:0] wb_dat_i,
    output logic [icu_pkg::ICU_DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic capture_pin_i,
    input wire logic [15:0] timebase_count_i,
    output logic [15:0] captured_value_o,
    output logic capture_event_flag_o,
    output logic capture_strobe_o,
    output logic [3:0] capture_mode_select_o
);
    import icu_pkg::*;

    // ****************************************************************
    // helper functions
    // ****************************************************************

    // true only for the four capture encodings
    function automatic logic is_capture_mode(input logic [3:0] mode);
        logic res;
        res = 1'b0;
        if (mode == ICU_MODE_FALL)
        begin
            res = 1'b1;
        end
        else if (mode == ICU_MODE_RISE)
        begin
            res = 1'b1;
        end
        else if (mode == ICU_MODE_RISE4)
        begin
            res = 1'b1;
        end
        else if (mode == ICU_MODE_RISE16)
        begin
            res = 1'b1;
        end
        return res;
    endfunction : is_capture_mode

    // byte-lane merge of a write into an old word
    function automatic logic [ICU_DATA_W-1:0] merge_lanes(
        input logic [ICU_DATA_W-1:0] old_word,
        input logic [ICU_DATA_W-1:0] new_word,
        input logic [ICU_SEL_W-1:0] sel
    );
        logic [ICU_DATA_W-1:0] res;
        res = old_word;
        for (int i = 0; i < ICU_SEL_W; i++)
        begin
            if (sel[i])
            begin
                res[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_lanes

    // ****************************************************************
    // state
    // ****************************************************************
    icu_state_t r;
    icu_state_t n;

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb
    begin
        logic rise;
        logic fall;
        logic hit;
        logic req;
        logic wr;
        logic [ICU_DATA_W-1:0] rd;
        logic [ICU_DATA_W-1:0] word;
        rise = 1'b0;
        fall = 1'b0;
        hit = 1'b0;
        req = 1'b0;
        wr = 1'b0;
        rd = '0;
        word = '0;
        n = r;

        // pin synchroniser; meta stage only feeds the sync stage
        n.pin_meta = capture_pin_i; // see RULE_14
        n.pin_sync = r.pin_meta; // see RULE_14
        n.pin_prev = r.pin_sync;

        // raw pin level is watched, never the direction bit
        rise = r.pin_sync & ~r.pin_prev; // see RULE_05
        fall = ~r.pin_sync & r.pin_prev; // see RULE_14

        // event qualification; no sleep gating, the edge path
        // only needs clk_i and the timebase value
        case (r.mode) // see RULE_02
            ICU_MODE_FALL:
            begin
                hit = fall;
            end
            ICU_MODE_RISE:
            begin
                hit = rise;
            end
            ICU_MODE_RISE4:
            begin
                hit = rise & (r.presc[1:0] == ICU_PRESC4_LAST);
            end
            ICU_MODE_RISE16:
            begin
                hit = rise & (r.presc == ICU_PRESC16_LAST); // see RULE_02
            end
            default:
            begin
                hit = 1'b0;
            end
        endcase

        // prescaler wraps freely, so a direct switch between /4 and
        // /16 keeps the count and can fire early
        if (!is_capture_mode(r.mode))
        begin
            n.presc = '0; // see RULE_10
        end
        else if (rise)
        begin
            n.presc = r.presc + 4'h1; // see RULE_12
        end

        // ************************************************************
        // wishbone slave: ack one cycle after request, write
        // commits on the edge that samples ack
        // ************************************************************
        req = wb_cyc_i & wb_stb_i;
        n.ack = req & ~r.ack;
        wr = req & r.ack & wb_we_i;

        if (wb_adr_i == ICU_OFF_CONTROL)
        begin
            rd[3:0] = r.mode;
        end
        else if (wb_adr_i == ICU_OFF_CAP_LOW)
        begin
            rd[7:0] = r.captured[7:0];
        end
        else if (wb_adr_i == ICU_OFF_CAP_HIGH)
        begin
            rd[7:0] = r.captured[15:8];
        end
        else if (wb_adr_i == ICU_OFF_FLAG)
        begin
            rd[ICU_FLAG_BIT] = r.flag;
        end
        else if (wb_adr_i == ICU_OFF_ENABLE)
        begin
            rd[ICU_ENABLE_BIT] = r.enable;
        end
        else if (wb_adr_i == ICU_OFF_STATUS)
        begin
            rd[ICU_ST_PRESC_LSB +: ICU_PRESC_W] = r.presc;
            rd[ICU_ST_PIN_BIT] = r.pin_sync;
            rd[ICU_ST_ACTIVE_BIT] = is_capture_mode(r.mode);
        end

        if (req & ~r.ack)
        begin
            n.rdata = rd;
        end

        if (wr)
        begin
            if (wb_adr_i == ICU_OFF_CONTROL)
            begin
                word = merge_lanes({28'h0000000, r.mode}, wb_dat_i, wb_sel_i);
                n.mode = word[3:0];
            end
            else if (wb_adr_i == ICU_OFF_CAP_LOW)
            begin
                word = merge_lanes({24'h000000, r.captured[7:0]}, wb_dat_i, wb_sel_i);
                n.captured[7:0] = word[7:0];
            end
            else if (wb_adr_i == ICU_OFF_CAP_HIGH)
            begin
                word = merge_lanes({24'h000000, r.captured[15:8]}, wb_dat_i, wb_sel_i);
                n.captured[15:8] = word[7:0];
            end
            else if (wb_adr_i == ICU_OFF_FLAG)
            begin
                word = merge_lanes({31'h00000000, r.flag}, wb_dat_i, wb_sel_i);
                n.flag = word[ICU_FLAG_BIT]; // see RULE_03
            end
            else if (wb_adr_i == ICU_OFF_ENABLE)
            begin
                // enable bit is only stored; spurious flags after a
                // mode change are left to software
                word = merge_lanes({31'h00000000, r.enable}, wb_dat_i, wb_sel_i);
                n.enable = word[ICU_ENABLE_BIT]; // see RULE_09
            end
        end

        // ************************************************************
        // capture: wins over a same-cycle software write
        // ************************************************************
        n.strobe = hit; // see RULE_14
        if (hit)
        begin
            n.captured = timebase_count_i; // see RULE_01
            n.flag = 1'b1; // see RULE_03
        end
        // old value silently lost if not yet read
        if (hit & r.strobe)
        begin
            n.captured = timebase_count_i; // see RULE_04
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            r <= ICU_STATE_RST; // see RULE_11
        end
        else
        begin
            r <= n;
        end
    end

    // ****************************************************************
    // outputs, all straight from the state register
    // ****************************************************************
    assign wb_dat_o = r.rdata;
    assign wb_ack_o = r.ack;
    assign captured_value_o = r.captured;
    assign capture_event_flag_o = r.flag;
    assign capture_strobe_o = r.strobe;
    assign capture_mode_select_o = r.mode;

endmodule : icu_capture_unit

// [hw/icu_pkg.sv]
// Purpose: constants and state type for the input capture unit
// Assumes: 32-bit classic Wishbone register bus, word-aligned registers
// Notes: all offsets are byte addresses

package icu_pkg;

    // ****************************************************************
    // bus geometry
    // ****************************************************************
    localparam int ICU_ADDR_W = 8;
    localparam int ICU_DATA_W = 32;
    localparam int ICU_SEL_W = 4;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [ICU_ADDR_W-1:0] ICU_OFF_CONTROL = 8'h00;
    localparam logic [ICU_ADDR_W-1:0] ICU_OFF_CAP_LOW = 8'h04;
    localparam logic [ICU_ADDR_W-1:0] ICU_OFF_CAP_HIGH = 8'h08;
    localparam logic [ICU_ADDR_W-1:0] ICU_OFF_FLAG = 8'h0c;
    localparam logic [ICU_ADDR_W-1:0] ICU_OFF_ENABLE = 8'h10;
    localparam logic [ICU_ADDR_W-1:0] ICU_OFF_STATUS = 8'h14;

    // ****************************************************************
    // capture_mode_select encodings
    // ****************************************************************
    localparam logic [3:0] ICU_MODE_OFF = 4'h0;
    localparam logic [3:0] ICU_MODE_FALL = 4'h4;
    localparam logic [3:0] ICU_MODE_RISE = 4'h5;
    localparam logic [3:0] ICU_MODE_RISE4 = 4'h6;
    localparam logic [3:0] ICU_MODE_RISE16 = 4'h7;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int ICU_PRESC_W = 4;
    localparam int ICU_FLAG_BIT = 0;
    localparam int ICU_ENABLE_BIT = 0;
    localparam int ICU_ST_PRESC_LSB = 0;
    localparam int ICU_ST_PIN_BIT = 4;
    localparam int ICU_ST_ACTIVE_BIT = 5;
    localparam logic [1:0] ICU_PRESC4_LAST = 2'h3;
    localparam logic [3:0] ICU_PRESC16_LAST = 4'hf;

    // ****************************************************************
    // state of the unit
    // ****************************************************************
    typedef struct packed {
        logic pin_meta;
        logic pin_sync;
        logic pin_prev;
        logic [3:0] mode;
        logic [15:0] captured;
        logic flag;
        logic enable;
        logic [ICU_PRESC_W-1:0] presc;
        logic strobe;
        logic ack;
        logic [ICU_DATA_W-1:0] rdata;
    } icu_state_t;

    localparam icu_state_t ICU_STATE_RST = '0;

endpackage : icu_pkg

// [tb/icu_capture_unit_props.sv]
// Purpose: port-level checks of the input capture unit
// Assumes: one clock, synchronous active-high reset
// Notes: capture strobe seen one edge after it is launched

// ****************************************************************
// checker
// ****************************************************************
module icu_capture_unit_props
    import icu_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic capture_pin_i,
    input wire logic [15:0] timebase_count_i,
    input wire logic [15:0] captured_value_o,
    input wire logic capture_event_flag_o,
    input wire logic capture_strobe_o,
    input wire logic [3:0] capture_mode_select_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic cap_mode;
    // codes 4..7 are the capture codes
    assign cap_mode = capture_mode_select_o[3:2] == 2'h1;

    a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request without ack");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_strobe_pulse: assert property (capture_strobe_o |=> !capture_strobe_o)
        else $error("capture strobe too long");
    a_cap_copies: assert property (
        capture_strobe_o |-> captured_value_o == $past(timebase_count_i))
        else $error("captured value not the timebase");
    a_cap_flag: assert property (capture_strobe_o |-> capture_event_flag_o)
        else $error("capture without flag");
    a_flag_sticky: assert property (
        $fell(capture_event_flag_o) |-> $past(wb_ack_o && wb_we_i))
        else $error("flag cleared without a write");
    a_value_held: assert property (
        $changed(captured_value_o) |-> capture_strobe_o || $past(wb_ack_o && wb_we_i))
        else $error("captured value changed without cause");
    a_off_quiet: assert property (
        !cap_mode && $past(!cap_mode) |-> !capture_strobe_o)
        else $error("capture outside capture mode");
    a_edge_kind: assert property (
        capture_strobe_o |-> $past(capture_pin_i, 2) == (capture_mode_select_o != ICU_MODE_FALL))
        else $error("capture on the wrong edge");
endmodule : icu_capture_unit_props

bind icu_capture_unit icu_capture_unit_props props_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_ack_o, .capture_pin_i, .timebase_count_i, .captured_value_o,
    .capture_event_flag_o, .capture_strobe_o, .capture_mode_select_o);

// [tb/icu_pin_source.sv]
// Purpose: external source driving the capture pin
// Assumes: edges launched just after a rising clock edge
// Notes: pin always an input of the unit here

module icu_pin_source
(
    input wire logic clk_i,
    output logic pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pin_o = 1'b0;

    // 3 high, 5 low: wider than the synchroniser needs
    task automatic rises(input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            pin_o <= 1'b1;
            repeat (3) @(posedge clk_i);
            pin_o <= 1'b0;
            repeat (5) @(posedge clk_i);
        end
    endtask : rises
endmodule : icu_pin_source

// [tb/input_capture_unit_tb_top.sv]
// Purpose: register-level test of the input capture unit
// Assumes: timebase counts on the unit's own clock
// Notes: capture count kept by the bench, not the unit

module input_capture_unit_tb_top
    import icu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, capture_pin_i;
    logic capture_event_flag_o, capture_strobe_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, capture_mode_select_o, m;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [15:0] timebase_count_i, captured_value_o, last_cap, tb_prev;
    logic [1:0] tb_div;
    int miscompares, comparisons, strobes, s0, i;

    icu_capture_unit dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .capture_pin_i, .timebase_count_i,
        .captured_value_o, .capture_event_flag_o, .capture_strobe_o, .capture_mode_select_o);
    icu_pin_source src_u (.clk_i(clk_i), .pin_o(capture_pin_i));

    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // ****************************************************************
    // timebase and capture bookkeeping
    // ****************************************************************
    // timebase steps on a clk/4 enable, never on every system clock
    always @(posedge clk_i)
    begin
        tb_div <= tb_div + 2'h1;
        if (tb_div == 2'h3)
        begin
            timebase_count_i <= timebase_count_i + 16'h1;
        end
        tb_prev <= timebase_count_i;
        if (capture_strobe_o === 1'b1)
        begin
            strobes <= strobes + 1;
            last_cap <= tb_prev;
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task test_done;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    // waits for ack under a bound; no fixed latency assumed
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++)
            @(posedge clk_i);
        if (wb_ack_o !== 1'b1)
        begin
            miscompares++;
            test_done();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc

    task cap_chk;
        rdc(ICU_OFF_CAP_LOW, {24'h0, last_cap[7:0]});
        rdc(ICU_OFF_CAP_HIGH, {24'h0, last_cap[15:8]});
        rdc(ICU_OFF_FLAG, 32'h1);
        chk({16'h0, captured_value_o}, {16'h0, last_cap});
    endtask : cap_chk

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        timebase_count_i = 16'h12f0;
        tb_div = 2'h0;
        strobes = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(ICU_OFF_STATUS, 32'h0);
        rdc(8'h40, 32'h0);
        wb(1'b1, ICU_OFF_CONTROL, {28'h0, ICU_MODE_RISE});
        rdc(ICU_OFF_CONTROL, {28'h0, ICU_MODE_RISE});
        chk({28'h0, capture_mode_select_o}, {28'h0, ICU_MODE_RISE});
        wb(1'b1, ICU_OFF_ENABLE, 32'h1);
        rdc(ICU_OFF_ENABLE, 32'h1);
        src_u.rises(1);
        chk(strobes, 1);
        cap_chk();
        wb(1'b1, ICU_OFF_CONTROL, {28'h0, ICU_MODE_FALL});
        src_u.rises(1);
        chk(strobes, 2);
        cap_chk();
        wb(1'b1, ICU_OFF_FLAG, 32'h0);
        rdc(ICU_OFF_FLAG, 32'h0);
        for (i = 0; i < 2; i++)
        begin
            m = (i == 0) ? ICU_MODE_RISE4 : ICU_MODE_RISE16;
            wb(1'b1, ICU_OFF_CONTROL, 32'h0);
            rdc(ICU_OFF_STATUS, 32'h0);
            wb(1'b1, ICU_OFF_CONTROL, {28'h0, m});
            s0 = strobes;
            src_u.rises((i == 0) ? 3 : 15);
            chk(strobes, s0);
            src_u.rises(1);
            chk(strobes, s0 + 1);
            cap_chk();
        end
        wb(1'b1, ICU_OFF_CONTROL, 32'h0);
        wb(1'b1, ICU_OFF_CONTROL, {28'h0, ICU_MODE_RISE4});
        src_u.rises(2);
        wb(1'b1, ICU_OFF_CONTROL, {28'h0, ICU_MODE_RISE16});
        rdc(ICU_OFF_STATUS, 32'h22);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(ICU_OFF_STATUS, 32'h0);
        test_done();
    end
endmodule : input_capture_unit_tb_top
